// file: src/lmd_pkg.sv
// Shared constants, register map and types of the LED matrix control block.
// Assumes a 250 MHz core clock and an SPI link clocked by the host.
package lmd_pkg;
  // Matrix geometry
  localparam int CS_NUM = 18;
  localparam int SW_NUM = 4;
  localparam int LED_NUM = 72;
  localparam int PWM_STEPS = 256;

  // Register pages and addresses
  localparam logic [3:0] PAGE_PWM = 4'h0;
  localparam logic [3:0] PAGE_CFG = 4'h1;
  localparam logic [7:0] ADDR_DOT_FIRST = 8'h01;
  localparam logic [7:0] ADDR_DOT_LAST = 8'h48;
  localparam logic [7:0] ADDR_CONFIG = 8'h50;
  localparam logic [7:0] ADDR_GCC = 8'h51;
  localparam logic [7:0] ADDR_PULL = 8'h52;
  localparam logic [7:0] ADDR_FAULT_FIRST = 8'h53;
  localparam logic [7:0] ADDR_FAULT_LAST = 8'h5e;
  localparam int FAULT_BYTES = 9;

  // Field positions and reset values
  localparam int CFG_SSD_BIT = 0;
  localparam int CFG_SEL_LO = 1;
  localparam int PULL_CS_LO = 0;
  localparam int PULL_SW_LO = 4;
  localparam int PULL_SEL_W = 3;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] GCC_RESET = 8'h00;
  localparam logic [7:0] PULL_RESET = 8'h00;
  localparam logic [7:0] DOT_RESET = 8'h00;
  localparam logic [1:0] SEL_OFF = 2'h0;
  localparam logic [1:0] SEL_OPEN = 2'h1;
  localparam logic [1:0] SEL_SHORT = 2'h2;

  // SPI frame: command byte, address byte, data byte
  localparam int SPI_FRAME_BITS = 24;
  localparam int SPI_HDR_BITS = 16;
  localparam int SPI_RD_BIT = 15;

  // Timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int SPI_CLR_NS = 16;
  localparam int SPI_CLR_CYCLES = (SPI_CLR_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int DETECT_SCAN_CYCLES = 2;

  typedef enum logic [1:0] {DET_IDLE, DET_ARMED, DET_RUN} lmd_det_t;
endpackage

// file: src/lmd_spi_link.sv
// SPI slave front end running on the host's serial clock.
// Assumes mode 0 frames of 24 bits under chip select; the clock stands still between frames.
`timescale 1ns/1ps
module lmd_spi_link (
  // Serial pins
  input wire logic i_sck,
  input wire logic i_cs_b,
  input wire logic i_mosi,
  output logic o_miso,
  output logic o_miso_oe,
  // Core side
  input wire logic i_clr,
  input wire logic [7:0] i_rdata,
  output logic o_wr_tgl,
  output logic [3:0] o_page,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata
);
  import lmd_pkg::*;

  logic frame_rst;
  logic [4:0] bit_cnt_q;
  logic [14:0] sh_q;
  logic [15:0] hdr;
  logic is_rd_q;
  logic [6:0] out_sh_q;

  // Chip select ends a frame; a clear from the core aborts everything
  assign frame_rst = i_cs_b | i_clr;
  assign hdr = {sh_q, i_mosi};

  always_ff @(posedge i_sck or posedge frame_rst) begin
    if (frame_rst) begin
      bit_cnt_q <= 5'h00;
      sh_q <= 15'h0000;
    end else begin
      sh_q <= hdr[14:0];
      if (bit_cnt_q != 5'(SPI_FRAME_BITS)) begin
        bit_cnt_q <= bit_cnt_q + 5'h01;
      end
    end
  end

  // Word registers outlive the frame so the core can take them after chip select rises
  always_ff @(posedge i_sck or posedge i_clr) begin
    if (i_clr) begin
      is_rd_q <= 1'b0;
      o_page <= 4'h0;
      o_addr <= 8'h00;
      o_wdata <= 8'h00;
      o_wr_tgl <= 1'b0;
    end else if (bit_cnt_q == 5'(SPI_HDR_BITS - 1)) begin
      is_rd_q <= hdr[SPI_RD_BIT];
      o_page <= hdr[11:8];
      o_addr <= hdr[7:0];
    end else if (bit_cnt_q == 5'(SPI_FRAME_BITS - 1) && !is_rd_q) begin
      o_wdata <= hdr[7:0];
      o_wr_tgl <= ~o_wr_tgl;
    end
  end

  // Read data leaves on falling edges; the core has half a bit time to settle it
  always_ff @(negedge i_sck or posedge frame_rst) begin
    if (frame_rst) begin
      o_miso <= 1'b0;
      o_miso_oe <= 1'b0;
      out_sh_q <= 7'h00;
    end else if (bit_cnt_q == 5'(SPI_HDR_BITS)) begin
      o_miso <= i_rdata[7];
      out_sh_q <= i_rdata[6:0];
      o_miso_oe <= is_rd_q;
    end else if (bit_cnt_q > 5'(SPI_HDR_BITS)) begin
      o_miso <= out_sh_q[6];
      out_sh_q <= {out_sh_q[5:0], 1'b0};
    end
  end
endmodule

// file: src/lmd_ctrl.sv
// Control core of an 18x4 LED matrix driver: registers, scan, fault detect, de-ghost, shutdown.
// Assumes analog sinks and switches outside, a host on SPI and an asynchronous shutdown pin.
// Functional notes
// - PWM only; each 8-bit value selects one of 256 duty steps.
// - Detect select moving from 00 to 01 or 10 starts fault capture.
// - Fault results valid only after two full scan cycles; host waits.
// - LEDs with zero dot scaling keep their fault bit unchanged.
// - Pull select 0x00 disables all switch pull-downs and sink pull-ups.
// - One detection pass per trigger, never repeated while select stays nonzero.
// - Pull-downs on four switches, pull-ups on eighteen sinks, chosen by register.
// - Pull resistors connect only while their output is off.
// - Shutdown pin rising edge resets the SPI logic.
// - Shutdown of either kind preserves all registers.
// - Soft shutdown bit written 0 enters software shutdown.
// - Software shutdown switches all current sources off.
// - Registers stay readable and writable in software shutdown.
// - Shutdown pin low disables analog; high releases it.
// - Registers stay accessible in hardware shutdown.
`timescale 1ns/1ps
module lmd_ctrl (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // SPI link
  input wire logic i_sck,
  input wire logic i_cs_b,
  input wire logic i_mosi,
  output logic o_miso,
  output logic o_miso_oe,
  // Shutdown pin and analog enable
  input wire logic i_shutdown_pin,
  output logic o_analog_en,
  // Matrix drive
  output logic [lmd_pkg::SW_NUM-1:0] o_scan_switch_outputs,
  output logic [lmd_pkg::CS_NUM-1:0] o_current_sink_outputs,
  output logic [7:0] o_global_current_level,
  // De-ghost resistors
  output logic [lmd_pkg::SW_NUM-1:0] o_sw_pull_en,
  output logic [lmd_pkg::CS_NUM-1:0] o_cs_pull_en,
  output logic [lmd_pkg::PULL_SEL_W-1:0] o_sw_pull_sel,
  output logic [lmd_pkg::PULL_SEL_W-1:0] o_cs_pull_sel,
  // Fault detection
  input wire logic [lmd_pkg::CS_NUM-1:0] i_led_fault,
  output logic o_detect_busy
);
  import lmd_pkg::*;

  function automatic logic in_dot(input logic [7:0] a);
    return (a >= ADDR_DOT_FIRST) && (a <= ADDR_DOT_LAST);
  endfunction

  function automatic logic [6:0] led_of_addr(input logic [7:0] a);
    return 7'(a - ADDR_DOT_FIRST);
  endfunction

  function automatic logic [6:0] led_at(input logic [1:0] sw, input int cs);
    return 7'(int'(sw) * CS_NUM + cs);
  endfunction

  // Register storage
  logic [7:0] pwm_q [LED_NUM];
  logic [7:0] scale_q [LED_NUM];
  logic [7:0] cfg_q;
  logic [7:0] gcc_q;
  logic [7:0] pull_q;
  logic [LED_NUM-1:0] fault_q;
  logic [LED_NUM-1:0] fault_d;

  // Link crossing
  logic spi_wr_tgl;
  logic [3:0] spi_page;
  logic [7:0] spi_addr;
  logic [7:0] spi_wdata;
  logic spi_clr_q;
  logic [2:0] clr_cnt_q;
  logic wr_s1_q, wr_s2_q, wr_s3_q, wr_lvl_q, wr_ref_q;
  logic wr_take;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  // Shutdown pin and fault comparator synchronisers
  logic sdb_s1_q, sdb_s2_q, sdb_s3_q, sdb_lvl_q;
  logic sdb_rise;
  logic [CS_NUM-1:0] flt_s1_q, flt_s2_q, flt_s3_q, flt_q;

  // Scan and detection
  logic run;
  logic [1:0] sw_idx_q;
  logic [7:0] pwm_cnt_q;
  logic cyc_end, smp;
  lmd_det_t det_q;
  lmd_det_t det_d;
  logic [0:0] det_cyc_q;
  logic trig;
  logic [CS_NUM-1:0] cs_on_d;
  logic [SW_NUM-1:0] sw_on_d;

  lmd_spi_link u_link (
    .i_sck(i_sck),
    .i_cs_b(i_cs_b),
    .i_mosi(i_mosi),
    .o_miso(o_miso),
    .o_miso_oe(o_miso_oe),
    .i_clr(spi_clr_q),
    .i_rdata(rdata_q),
    .o_wr_tgl(spi_wr_tgl),
    .o_page(spi_page),
    .o_addr(spi_addr),
    .o_wdata(spi_wdata)
  );

  // Pin and fault synchronisers: a change counts once stages two and three agree
  always_ff @(posedge i_ref_clk) begin
    sdb_s1_q <= i_shutdown_pin;
    sdb_s2_q <= sdb_s1_q;
    sdb_s3_q <= sdb_s2_q;
    flt_s1_q <= i_led_fault;
    flt_s2_q <= flt_s1_q;
    flt_s3_q <= flt_s2_q;
    if (!i_rst_b) begin
      sdb_lvl_q <= 1'b0;
      flt_q <= '0;
    end else begin
      sdb_lvl_q <= (sdb_s2_q == sdb_s3_q) ? sdb_s3_q : sdb_lvl_q;
      flt_q <= (flt_s2_q & flt_s3_q) | (flt_q & (flt_s2_q ^ flt_s3_q));
    end
  end

  assign sdb_rise = sdb_s3_q & sdb_s2_q & ~sdb_lvl_q;

  // The link logic is held cleared through reset and briefly after each pin rise
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      clr_cnt_q <= 3'(SPI_CLR_CYCLES);
      spi_clr_q <= 1'b1;
    end else if (sdb_rise) begin
      clr_cnt_q <= 3'(SPI_CLR_CYCLES);
      spi_clr_q <= 1'b1;
    end else begin
      clr_cnt_q <= (clr_cnt_q != 3'h0) ? clr_cnt_q - 3'h1 : 3'h0;
      spi_clr_q <= (clr_cnt_q > 3'h1);
    end
  end

  // The write toggle is forced to the cleared value so a link reset is never seen as a write
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b || spi_clr_q) begin
      wr_s1_q <= 1'b0;
      wr_s2_q <= 1'b0;
      wr_s3_q <= 1'b0;
      wr_lvl_q <= 1'b0;
      wr_ref_q <= 1'b0;
    end else begin
      wr_s1_q <= spi_wr_tgl;
      wr_s2_q <= wr_s1_q;
      wr_s3_q <= wr_s2_q;
      wr_lvl_q <= (wr_s2_q == wr_s3_q) ? wr_s3_q : wr_lvl_q;
      wr_ref_q <= wr_lvl_q;
    end
  end

  assign wr_take = wr_lvl_q != wr_ref_q;

  // Write decode; no shutdown state gates the register port
  logic wr_pwm, wr_scale, wr_cfg, wr_gcc, wr_pull;
  logic [6:0] wr_led;
  assign wr_led = led_of_addr(spi_addr);
  assign wr_pwm = wr_take && spi_page == PAGE_PWM && in_dot(spi_addr);
  assign wr_scale = wr_take && spi_page == PAGE_CFG && in_dot(spi_addr);
  assign wr_cfg = wr_take && spi_page == PAGE_CFG && spi_addr == ADDR_CONFIG;
  assign wr_gcc = wr_take && spi_page == PAGE_CFG && spi_addr == ADDR_GCC;
  assign wr_pull = wr_take && spi_page == PAGE_CFG && spi_addr == ADDR_PULL;
  assign trig = wr_cfg && cfg_q[CFG_SEL_LO +: 2] == SEL_OFF &&
                (spi_wdata[CFG_SEL_LO +: 2] == SEL_OPEN || spi_wdata[CFG_SEL_LO +: 2] == SEL_SHORT);

  // Registers only change on a write or on reset, never on shutdown
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      for (int i = 0; i < LED_NUM; i++) begin
        pwm_q[i] <= DOT_RESET;
        scale_q[i] <= DOT_RESET;
      end
      cfg_q <= CFG_RESET;
      gcc_q <= GCC_RESET;
      pull_q <= PULL_RESET;
    end else begin
      if (wr_pwm) pwm_q[wr_led] <= spi_wdata;
      if (wr_scale) scale_q[wr_led] <= spi_wdata;
      if (wr_cfg) cfg_q <= spi_wdata;
      if (wr_gcc) gcc_q <= spi_wdata;
      if (wr_pull) pull_q <= spi_wdata;
    end
  end

  // Read mux; the address word is quasi-static, stable well before the first output bit
  logic [3:0] flt_byte;
  assign flt_byte = 4'(spi_addr - ADDR_FAULT_FIRST);
  always_comb begin
    rdata_d = 8'h00;
    if (spi_page == PAGE_PWM && in_dot(spi_addr)) begin
      rdata_d = pwm_q[led_of_addr(spi_addr)];
    end else if (spi_page == PAGE_CFG) begin
      if (in_dot(spi_addr)) rdata_d = scale_q[led_of_addr(spi_addr)];
      else if (spi_addr == ADDR_CONFIG) rdata_d = cfg_q;
      else if (spi_addr == ADDR_GCC) rdata_d = gcc_q;
      else if (spi_addr == ADDR_PULL) rdata_d = pull_q;
      else if (spi_addr >= ADDR_FAULT_FIRST && spi_addr <= ADDR_FAULT_LAST && flt_byte < 4'(FAULT_BYTES)) begin
        rdata_d = fault_q[flt_byte * 8 +: 8];
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    rdata_q <= i_rst_b ? rdata_d : 8'h00;
  end

  // Scan engine: 256 PWM counts per switch, four switches per scan cycle
  assign run = cfg_q[CFG_SSD_BIT] && sdb_lvl_q;
  assign cyc_end = run && sw_idx_q == 2'(SW_NUM - 1) && pwm_cnt_q == 8'(PWM_STEPS - 1);

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b || !run) begin
      pwm_cnt_q <= 8'h00;
      sw_idx_q <= 2'h0;
    end else begin
      pwm_cnt_q <= pwm_cnt_q + 8'h01;
      if (pwm_cnt_q == 8'(PWM_STEPS - 1)) sw_idx_q <= sw_idx_q + 2'h1;
    end
  end

  always_comb begin
    for (int j = 0; j < CS_NUM; j++) begin
      cs_on_d[j] = run && (pwm_cnt_q < pwm_q[led_at(sw_idx_q, j)]) &&
                   (scale_q[led_at(sw_idx_q, j)] != 8'h00);
    end
    sw_on_d = run ? SW_NUM'(1) << sw_idx_q : '0;
  end

  // Detection: one pass of two whole scan cycles per trigger
  assign smp = det_q == DET_RUN && run && pwm_cnt_q == 8'(PWM_STEPS - 1);

  always_comb begin
    det_d = det_q;
    if (trig) begin
      det_d = DET_ARMED;
    end else begin
      unique case (det_q)
        DET_IDLE: det_d = DET_IDLE;
        // Enter on the last count so the pass begins exactly at switch 0, count 0
        DET_ARMED: if (cyc_end) det_d = DET_RUN;
        DET_RUN: if (cyc_end && det_cyc_q == 1'(DETECT_SCAN_CYCLES - 1)) det_d = DET_IDLE;
        default: det_d = DET_IDLE;
      endcase
    end
  end

  always_comb begin
    fault_d = fault_q;
    if (smp) begin
      for (int j = 0; j < CS_NUM; j++) begin
        if (scale_q[led_at(sw_idx_q, j)] != 8'h00) fault_d[led_at(sw_idx_q, j)] = flt_q[j];
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      det_q <= DET_IDLE;
      det_cyc_q <= 1'b0;
      fault_q <= '0;
    end else begin
      det_q <= det_d;
      det_cyc_q <= (det_q != DET_RUN) ? 1'b0 : det_cyc_q ^ cyc_end;
      fault_q <= fault_d;
    end
  end

  // Every output leaves from a flop
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_analog_en <= 1'b0;
      o_scan_switch_outputs <= '0;
      o_current_sink_outputs <= '0;
      o_global_current_level <= 8'h00;
      o_sw_pull_en <= '0;
      o_cs_pull_en <= '0;
      o_sw_pull_sel <= '0;
      o_cs_pull_sel <= '0;
      o_detect_busy <= 1'b0;
    end else begin
      o_analog_en <= sdb_lvl_q;
      o_scan_switch_outputs <= sw_on_d;
      o_current_sink_outputs <= cs_on_d;
      o_global_current_level <= gcc_q;
      // Pull resistors stay on in hardware shutdown unless software clears the select
      o_sw_pull_en <= (pull_q[PULL_SW_LO +: PULL_SEL_W] != '0) ? ~sw_on_d : '0;
      o_cs_pull_en <= (pull_q[PULL_CS_LO +: PULL_SEL_W] != '0) ? ~cs_on_d : '0;
      o_sw_pull_sel <= pull_q[PULL_SW_LO +: PULL_SEL_W];
      o_cs_pull_sel <= pull_q[PULL_CS_LO +: PULL_SEL_W];
      o_detect_busy <= det_d != DET_IDLE;
    end
  end

  // Checks
  logic [11:0] busy_len_q;
  always_ff @(posedge i_ref_clk) begin
    busy_len_q <= (!i_rst_b || det_q != DET_RUN) ? 12'h000 : busy_len_q + 12'h001;
  end

  a_pwm_step: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    o_current_sink_outputs[0] |-> $past(pwm_cnt_q) < $past(pwm_q[led_at(sw_idx_q, 0)]))
    else $error("sink on beyond its duty step");
  a_detect_start: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    trig |=> det_q == DET_ARMED ##1 o_detect_busy)
    else $error("trigger did not arm detection");
  a_detect_span: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (det_q == DET_RUN && det_d == DET_IDLE) |-> busy_len_q == 12'(DETECT_SCAN_CYCLES * SW_NUM * PWM_STEPS - 1))
    else $error("detection pass not two full scan cycles");
  a_dark_keeps: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (smp && scale_q[led_at(sw_idx_q, 0)] == 8'h00) |=>
    fault_q[led_at($past(sw_idx_q), 0)] == $past(fault_q[led_at(sw_idx_q, 0)]))
    else $error("fault bit of dark LED changed");
  a_pull_off: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    pull_q == 8'h00 |=> o_sw_pull_en == '0 && o_cs_pull_en == '0)
    else $error("pull resistor on with zero select");
  a_one_shot: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (det_q == DET_IDLE && !trig) |=> det_q == DET_IDLE)
    else $error("detection restarted without trigger");
  a_pull_idle: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (o_cs_pull_en & o_current_sink_outputs) == '0 && (o_sw_pull_en & o_scan_switch_outputs) == '0)
    else $error("pull resistor on a driving output");
  a_spi_clear: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    sdb_rise |=> spi_clr_q [*4] ##1 !spi_clr_q)
    else $error("link not cleared after pin rise");
  a_soft_blank: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    !cfg_q[CFG_SSD_BIT] |=> o_current_sink_outputs == '0 && o_scan_switch_outputs == '0)
    else $error("sinks on in software shutdown");
  a_hw_off: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    !sdb_lvl_q |=> !o_analog_en && o_current_sink_outputs == '0)
    else $error("analog on in hardware shutdown");
  a_write_kept: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    wr_gcc |=> gcc_q == $past(spi_wdata) ##1 o_global_current_level == $past(spi_wdata, 2))
    else $error("write lost in shutdown");

  c_trigger: cover property (@(posedge i_ref_clk) disable iff (!i_rst_b) trig);
  c_pass_done: cover property (@(posedge i_ref_clk) disable iff (!i_rst_b) $fell(o_detect_busy));
  c_pin_rise: cover property (@(posedge i_ref_clk) disable iff (!i_rst_b) sdb_rise);
  c_resume: cover property (@(posedge i_ref_clk) disable iff (!i_rst_b) $rose(run));
endmodule

// file: testbench/lmd_host_model.sv
// Host microcontroller model driving the SPI pins of the LED matrix core.
// Assumes mode 0 frames of 24 bits; its 80 ns serial clock runs only inside frames.
`timescale 1ns/1ps
module lmd_host_model (
  // Serial pins toward the device
  output logic o_sck,
  output logic o_cs_b,
  output logic o_mosi,
  input wire logic i_miso,
  input wire logic i_miso_oe
);
  logic [23:0] frame;

  initial begin
    o_sck = 1'b0;
    o_cs_b = 1'b1;
    o_mosi = 1'b0;
  end

  // One frame: command, address, data; read data is taken only while the device drives
  task automatic xfer(input logic rd, input logic [3:0] page, input logic [7:0] addr,
                      input logic [7:0] wdata, output logic [7:0] rdata);
    int i;
    frame = {rd, 3'h0, page, addr, wdata};
    rdata = 8'h00;
    #1.3;
    o_cs_b = 1'b0;
    for (i = 23; i >= 0; i--) begin
      o_mosi = frame[i];
      #40;
      o_sck = 1'b1;
      if (i < 8) begin
        rdata[i] = i_miso_oe ? i_miso : 1'bx;
      end
      #40;
      o_sck = 1'b0;
    end
    #20;
    o_cs_b = 1'b1;
    // Idle data line flips so a stale level is never mistaken for data
    o_mosi = ~o_mosi;
    // Gap covers the write spacing and the core's landing delay
    #120;
  endtask
endmodule

// file: testbench/tb.sv
// Self-checking bench for the LED matrix control core.
// Assumes the host model drives SPI; the bench drives reset, shutdown pin and fault inputs.
`timescale 1ns/1ps
module tb;
  import lmd_pkg::*;
  logic i_ref_clk;
  logic i_rst_b;
  logic i_shutdown_pin;
  logic [CS_NUM-1:0] i_led_fault;
  logic sck, cs_b, mosi, miso, miso_oe, analog_en, busy;
  logic [SW_NUM-1:0] sw_out, sw_pull_en;
  logic [CS_NUM-1:0] cs_out, cs_pull_en;
  logic [PULL_SEL_W-1:0] sw_sel, cs_sel;
  logic [7:0] gcc_out, v, g, fb;
  logic [17:0] pat;
  int fail_count, tests_run, cycles, n;

  lmd_ctrl uut (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_sck(sck), .i_cs_b(cs_b), .i_mosi(mosi),
    .o_miso(miso), .o_miso_oe(miso_oe), .i_shutdown_pin(i_shutdown_pin), .o_analog_en(analog_en),
    .o_scan_switch_outputs(sw_out), .o_current_sink_outputs(cs_out), .o_global_current_level(gcc_out),
    .o_sw_pull_en(sw_pull_en), .o_cs_pull_en(cs_pull_en), .o_sw_pull_sel(sw_sel), .o_cs_pull_sel(cs_sel),
    .i_led_fault(i_led_fault), .o_detect_busy(busy));
  lmd_host_model host (.o_sck(sck), .o_cs_b(cs_b), .o_mosi(mosi), .i_miso(miso), .i_miso_oe(miso_oe));

  always #2 i_ref_clk = ~i_ref_clk;

  function automatic int pwm_on(input logic [7:0] d);
    return int'(d);
  endfunction

  // Lit LEDs take the comparator level, dark ones keep their old bit
  function automatic logic [7:0] fault_exp(input logic [7:0] old, input logic [17:0] p, input logic [7:0] lit);
    return (old & ~lit) | (p[7:0] & lit);
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic wr(input logic [3:0] p, input logic [7:0] a, input logic [7:0] d);
    logic [7:0] x;
    host.xfer(1'b0, p, a, d, x);
    @(negedge i_ref_clk);
  endtask

  task automatic rd(input logic [3:0] p, input logic [7:0] a, output logic [7:0] d);
    host.xfer(1'b1, p, a, 8'h00, d);
    @(negedge i_ref_clk);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(PAGE_CFG, a, d);
    chk($sformatf("reg_%h", a), e, d);
  endtask

  task automatic wait_idle();
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 4000) begin
      @(negedge i_ref_clk);
      k++;
    end
    chk("detect_done", 1, k < 4000);
  endtask

  // One full scan holds every count of switch 0 exactly once, whatever the start phase
  task automatic count_led0(output int c);
    c = 0;
    repeat (SW_NUM * 256) begin
      @(negedge i_ref_clk);
      if (sw_out[0] === 1'b1 && cs_out[0] === 1'b1) begin
        c++;
      end
    end
  endtask

  task automatic pull_check(output int bad);
    bad = 0;
    repeat (1024) begin
      @(negedge i_ref_clk);
      if (sw_pull_en !== ~sw_out || cs_pull_en !== ~cs_out) begin
        bad++;
      end
    end
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 60000) begin
      fail_count++;
      end_of_test();
    end
  end

  initial begin
    i_ref_clk = 1'b0;
    i_rst_b = 1'b0;
    i_shutdown_pin = 1'b1;
    i_led_fault = '0;
    n = $urandom(27);
    repeat (12) @(negedge i_ref_clk);
    i_rst_b = 1'b1;
    repeat (12) @(negedge i_ref_clk);
    chk("analog_en", 1, analog_en);
    chk("blank_at_reset", 0, {sw_out, cs_out});
    rdc(ADDR_CONFIG, CFG_RESET);
    rdc(ADDR_PULL, PULL_RESET);
    rdc(ADDR_FAULT_FIRST, 8'h00);
    g = 8'h0f + 8'($urandom_range(49));  // Detection current window
    wr(PAGE_CFG, ADDR_GCC, g);
    rdc(ADDR_GCC, g);
    chk("gcc_out", g, gcc_out);
    wr(PAGE_CFG, 8'h4c, 8'h5a);
    rdc(8'h4c, 8'h00);
    wr(PAGE_CFG, ADDR_FAULT_FIRST, 8'hff);
    rdc(ADDR_FAULT_FIRST, 8'h00);
    rdc(8'h5c, 8'h00);
    // Matrix blank in soft shutdown, so every pull resistor connects
    v = (8'($urandom) & 8'h77) | 8'h11;
    wr(PAGE_CFG, ADDR_PULL, v);
    chk("sw_sel", v[6:4], sw_sel);
    chk("cs_sel", v[2:0], cs_sel);
    chk("pull_all", {4'hf, 18'h3ffff}, {sw_pull_en, cs_pull_en});
    wr(PAGE_CFG, ADDR_DOT_FIRST, 8'hff);
    wr(PAGE_PWM, ADDR_DOT_FIRST, 8'h80);
    wr(PAGE_CFG, ADDR_CONFIG, 8'h01);
    pull_check(n);
    chk("pull_vs_drive", 0, n);
    wr(PAGE_CFG, ADDR_PULL, 8'h00);  // Pulls off ahead of detection and pin shutdown
    chk("pull_off", 0, {sw_pull_en, cs_pull_en});
    wr(PAGE_CFG, ADDR_CONFIG, 8'h00);
    chk("soft_blank", 0, {sw_out, cs_out});
    v = 8'($urandom);
    wr(PAGE_PWM, ADDR_DOT_FIRST, v);
    rd(PAGE_PWM, ADDR_DOT_FIRST, fb);
    chk("pwm_in_soft_off", v, fb);
    wr(PAGE_CFG, ADDR_CONFIG, 8'h01);
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 8'h04 : (i == 1) ? 8'h00 : (i == 2) ? 8'hff : 8'($urandom);
      wr(PAGE_PWM, ADDR_DOT_FIRST, v);
      count_led0(n);
      chk("led0_on_cycles", pwm_on(v), n);
    end
    for (int i = 2; i <= 6; i++) begin
      wr(PAGE_CFG, 8'(i), 8'hff);
    end
    pat = 18'($urandom) | 18'h0ffc0;
    i_led_fault = pat;
    wr(PAGE_CFG, ADDR_CONFIG, 8'h03);  // Select moves from 00
    chk("busy_open", 1, busy);
    wait_idle();
    fb = fault_exp(8'h00, pat, 8'h3f);
    rdc(ADDR_FAULT_FIRST, fb);
    rdc(8'h54, 8'h00);
    pat = ~pat | 18'h0ffc0;
    i_led_fault = pat;
    wr(PAGE_CFG, ADDR_CONFIG, 8'h03);
    chk("no_rearm", 0, busy);
    repeat (3200) @(negedge i_ref_clk);
    rdc(ADDR_FAULT_FIRST, fb);
    wr(PAGE_CFG, ADDR_CONFIG, 8'h01);  // Clear before set
    wr(PAGE_CFG, ADDR_CONFIG, 8'h05);
    chk("busy_short", 1, busy);
    wait_idle();
    fb = fault_exp(fb, pat, 8'h3f);
    rdc(ADDR_FAULT_FIRST, fb);
    wr(PAGE_CFG, ADDR_CONFIG, 8'h01);
    wr(PAGE_CFG, ADDR_CONFIG, 8'h07);
    chk("sel_11_idle", 0, busy);
    i_shutdown_pin = 1'b0;
    repeat (10) @(negedge i_ref_clk);
    chk("hw_off", 0, {analog_en, sw_out, cs_out});
    g = 8'h0f + 8'($urandom_range(49));
    wr(PAGE_CFG, ADDR_GCC, g);
    rdc(ADDR_GCC, g);
    i_shutdown_pin = 1'b1;  // Rise only between frames
    repeat (20) @(negedge i_ref_clk);
    chk("hw_on", 1, analog_en);
    rdc(ADDR_GCC, g);
    rdc(ADDR_CONFIG, 8'h07);
    rdc(ADDR_FAULT_FIRST, fb);
    end_of_test();
  end
endmodule
